// file: include/tape_err_params.svh
// constants for the tape transfer error logic
`ifndef TAPE_ERR_PARAMS_SVH
`define TAPE_ERR_PARAMS_SVH
// register offsets
`define REG_CMD 4'h0
`define REG_STATUS 4'h1
`define REG_WCOUNT 4'h2
`define REG_XPORT 4'h3
// command field position and encodings
`define CMD_LSB 3
`define CMD_W 3
`define UNIT_W 3
`define CMD_READ 3'h0
`define CMD_REWIND 3'h1
`define CMD_SPFWD 3'h3
`define CMD_SPREV 3'h4
`define CMD_WRITE 3'h5
`define CMD_WEOF 3'h6
`define CMD_ERASE 3'h7
// status bit positions
`define ST_ERROR 0
`define ST_LATE 1
`define ST_ILLEGAL 3
`define ST_BUSY 4
`define ST_DONE 5
`define ST_PARITY 6
`define ST_EOF 7
`define ST_LOADPT 8
`define ST_PROTECT 9
`define ST_READY 10
`define ST_IRQ 11
// timing: erase length 2.5 in at 75 ips is 33333333 ns
`define ERASE_NS 33333333
`define CLK_NS 5
`define ERASE_CYC ((`ERASE_NS + `CLK_NS - 1) / `CLK_NS)
// total stop time (read, 800 bpi, 75 ips): 11.05 ms
`define STOP_NS 11050000
`define STOP_CYC ((`STOP_NS + `CLK_NS - 1) / `CLK_NS)
`endif

// file: include/tape_err_pkg.sv
// types for the tape transfer error logic
package tape_err_pkg;
    typedef enum logic [4:0] {
        ST_IDLE = 5'b00001,
        ST_RUN = 5'b00010,
        ST_CHECK = 5'b00100,
        ST_FINISH = 5'b01000,
        ST_STOP = 5'b10000
    } ctl_state_type;
endpackage

// file: rtl/pin_sync.sv
// three-stage pin synchroniser with agreement filter
`timescale 1ns/100ps
`default_nettype none
module pin_sync
#(
    parameter int WIDTH = 1
)
(
    input wire logic clk,
    input wire logic rstn,
    input wire logic [WIDTH-1:0] pin,
    output logic [WIDTH-1:0] level
);
    logic [WIDTH-1:0] s1_r;
    logic [WIDTH-1:0] s2_r;
    logic [WIDTH-1:0] s3_r;
    logic [WIDTH-1:0] level_r;
    wire [WIDTH-1:0] agree = ~(s2_r ^ s3_r);
    wire [WIDTH-1:0] level_nxt = (agree & s2_r) | (~agree & level_r);

    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            s1_r <= '0;
            s2_r <= '0;
            s3_r <= '0;
            level_r <= '0;
        end
        else
        begin
            s1_r <= pin;
            s2_r <= s1_r;
            s3_r <= s2_r;
            level_r <= level_nxt;
        end
    end

    assign level = level_r;
endmodule
`default_nettype wire

// file: rtl/lrc_acc.sv
// longitudinal check accumulator over a whole record
`timescale 1ns/100ps
`default_nettype none
module lrc_acc
#(
    parameter int WIDTH = 9
)
(
    input wire logic clk,
    input wire logic rstn,
    input wire logic clear,
    input wire logic char_valid,
    input wire logic [WIDTH-1:0] char_in,
    output logic [WIDTH-1:0] check
);
    logic [WIDTH-1:0] acc_r;

    // every character is folded in, transferred to memory or not
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
            acc_r <= '0;
        else if (clear)
            acc_r <= '0;
        else if (char_valid)
            acc_r <= acc_r ^ char_in;
    end

    assign check = acc_r;
endmodule
`default_nettype wire

// file: rtl/tape_transfer_error_logic.sv
// completion and error flag logic of the tape controller
// Function
// - erase runs about 2.5 inches of tape, then busy off, done on, interrupt
// - start on a not-ready transport sets illegal and done
// - illegal stays set until clear or io reset
// - clear and io reset zero error flags and command/select register
// - status reflects selected transport, transport 0 after clear
// - spacing on not-ready or reverse at load point: illegal, error, done
// - late channel on read sets late and error, read continues
// - file mark on read sets error and eof, ends with done and interrupt
// - bad character parity sets error and parity error, read continues
// - nrzi compares longitudinal check character, mismatch sets parity error
// - longitudinal check accumulates over whole record, not transferred part
// - write to not-ready or protected tape sets error, illegal, cause, done
// - late on write: pe runs to overflow, nrzi ends after next word
// - defective file mark is a short data record giving parity errors
// - 7-track nrzi file mark recorded with even parity
// - each channel word increments word counter, overflow ends transfer
// - busy high and done low while running, reverse on completion
`timescale 1ns/100ps
`default_nettype none
`include "tape_err_params.svh"
module tape_transfer_error_logic
    import tape_err_pkg::*;
#(
    parameter int ERASE_CYCLES = `ERASE_CYC,
    parameter int STOP_CYCLES = `STOP_CYC,
    parameter int NUNITS = 8
)
(
    input wire logic clk,
    input wire logic rstn,
    input wire logic [3:0] addr,
    input wire logic [15:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [15:0] rdata,
    input wire logic start,
    input wire logic clear_cmd,
    input wire logic io_reset,
    input wire logic [NUNITS-1:0] unit_ready,
    input wire logic [NUNITS-1:0] unit_protect,
    input wire logic [NUNITS-1:0] unit_loadpt,
    input wire logic [NUNITS-1:0] unit_nrzi,
    input wire logic [NUNITS-1:0] unit_7track,
    input wire logic char_valid,
    input wire logic [8:0] char_in,
    input wire logic char_parity_bad,
    input wire logic longitudinal_check_char_valid,
    input wire logic [8:0] longitudinal_check_char,
    input wire logic record_end_gap,
    input wire logic file_mark,
    input wire logic chan_word,
    input wire logic chan_late,
    input wire logic spaced_record,
    output logic write_stop,
    output logic eof_even_parity,
    output logic motion,
    output logic busy,
    output logic done,
    output logic irq
);
    // =========================================================
    // synchronised transport lines
    logic [NUNITS-1:0] ready_s;
    logic [NUNITS-1:0] protect_s;
    logic [NUNITS-1:0] loadpt_s;
    pin_sync #(.WIDTH(3 * NUNITS)) u_sync_lines
    (
        .clk(clk),
        .rstn(rstn),
        .pin({unit_loadpt, unit_protect, unit_ready}),
        .level({loadpt_s, protect_s, ready_s})
    );

    // =========================================================
    // registers
    logic [`CMD_W-1:0] cmd_r;
    logic [`UNIT_W-1:0] unit_r;
    logic [15:0] wcount_r;
    logic illegal_r;
    logic late_r;
    logic parity_r;
    logic eof_r;
    logic protect_err_r;
    logic busy_r;
    logic done_r;
    logic irq_r;
    logic stop_pend_r;
    logic [15:0] rdata_r;
    logic [31:0] timer_r;
    ctl_state_type state_r;
    ctl_state_type state_nxt;

    wire clr = clear_cmd | io_reset;
    wire sel_ready = ready_s[unit_r];
    wire sel_protect = protect_s[unit_r];
    wire sel_loadpt = loadpt_s[unit_r];
    wire sel_nrzi = unit_nrzi[unit_r];
    wire sel_7track = unit_7track[unit_r];
    wire is_space = (cmd_r == `CMD_SPFWD) || (cmd_r == `CMD_SPREV);
    wire is_write = (cmd_r == `CMD_WRITE) || (cmd_r == `CMD_WEOF) || (cmd_r == `CMD_ERASE);
    wire is_read = (cmd_r == `CMD_READ);
    // =========================================================
    // start screening
    wire start_ok = start && (state_r == ST_IDLE) && !clr;
    wire rev_at_lp = (cmd_r == `CMD_SPREV) && sel_loadpt;
    wire wr_prot = is_write && sel_protect;
    wire refuse = !sel_ready || (is_space && rev_at_lp) || wr_prot;
    wire go = start_ok && !refuse && !stop_pend_r && (cmd_r != `CMD_REWIND);
    wire running = (state_r == ST_RUN);

    // word counter overflow marks the end of a transfer
    wire wc_step = running && (chan_word || (is_space && spaced_record));
    wire wc_ovf = wc_step && (wcount_r == 16'hffff);
    wire late_ev = running && chan_late && (is_read || is_write);
    wire parity_ev = motion && is_read && char_parity_bad;
    wire eof_ev = running && (is_read || is_space) && file_mark;
    wire timer_zero = (timer_r == 32'h0);
    wire lrc_mis;
    wire lrc_ev = (state_r == ST_CHECK) && longitudinal_check_char_valid && lrc_mis;

    // =========================================================
    // operation sequencer
    always_comb
    begin
        state_nxt = state_r;
        case (state_r)
            ST_IDLE:
                if (go)
                    state_nxt = ST_RUN;
            ST_RUN:
                if (cmd_r == `CMD_ERASE)
                begin
                    if (timer_zero)
                        state_nxt = ST_FINISH;
                end
                else if (eof_ev)
                    state_nxt = ST_FINISH;
                else if (is_read && (wc_ovf || record_end_gap))
                    state_nxt = sel_nrzi ? ST_CHECK : ST_FINISH;
                else if (is_write && (wc_ovf || (sel_nrzi && late_r && chan_word)))
                    state_nxt = ST_FINISH;
                else if (wc_ovf || record_end_gap)
                    state_nxt = ST_FINISH;
            ST_CHECK:
                if (longitudinal_check_char_valid)
                    state_nxt = ST_FINISH;
            ST_FINISH:
                state_nxt = ST_STOP;
            ST_STOP:
                state_nxt = ST_IDLE;
            default:
                state_nxt = ST_IDLE;
        endcase
        if (clr)
            state_nxt = ST_IDLE;
    end

    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
            state_r <= ST_IDLE;
        else
            state_r <= state_nxt;
    end

    // erase length and stop time share one down counter
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
            timer_r <= 32'h0;
        else if (go)
            timer_r <= 32'(ERASE_CYCLES - 1);
        else if (state_r == ST_FINISH)
            timer_r <= 32'(STOP_CYCLES - 1);
        else if (!timer_zero)
            timer_r <= timer_r - 32'h1;
    end

    // new start held off until transport has stopped and settled
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
            stop_pend_r <= 1'b0;
        else if (state_r == ST_FINISH)
            stop_pend_r <= 1'b1;
        else if (timer_zero)
            stop_pend_r <= 1'b0;
    end

    // =========================================================
    // longitudinal check
    logic [8:0] lrc_calc;

    lrc_acc #(.WIDTH(9)) u_lrc
    (
        .clk(clk),
        .rstn(rstn),
        .clear(go),
        .char_valid(motion && char_valid),
        .char_in(char_in),
        .check(lrc_calc)
    );
    assign lrc_mis = (lrc_calc != longitudinal_check_char);

    // =========================================================
    // command, unit and word counter
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            cmd_r <= `CMD_READ;
            unit_r <= '0;
        end
        else if (clr)
        begin
            cmd_r <= `CMD_READ;
            unit_r <= '0;
        end
        else if (wr && addr == `REG_CMD && state_r == ST_IDLE)
        begin
            cmd_r <= wdata[`CMD_LSB +: `CMD_W];
            unit_r <= wdata[`UNIT_W-1:0];
        end
    end

    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
            wcount_r <= 16'h0;
        else if (wr && addr == `REG_WCOUNT)
            wcount_r <= wdata;
        else if (wc_step)
            wcount_r <= wcount_r + 16'h1;
    end

    // =========================================================
    // error flags: clear and io reset win over any set in the same cycle
    wire refuse_ev = start_ok && refuse;
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            illegal_r <= 1'b0;
            late_r <= 1'b0;
            parity_r <= 1'b0;
            eof_r <= 1'b0;
            protect_err_r <= 1'b0;
        end
        else if (clr)
        begin
            illegal_r <= 1'b0;
            late_r <= 1'b0;
            parity_r <= 1'b0;
            eof_r <= 1'b0;
            protect_err_r <= 1'b0;
        end
        else
        begin
            illegal_r <= illegal_r | refuse_ev;
            late_r <= late_r | late_ev;
            parity_r <= parity_r | parity_ev | lrc_ev;
            eof_r <= eof_r | eof_ev;
            protect_err_r <= protect_err_r | (refuse_ev && wr_prot);
        end
    end

    wire error_flag = illegal_r | late_r | parity_r | eof_r | protect_err_r;

    // =========================================================
    // busy, done and interrupt request
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            busy_r <= 1'b0;
            done_r <= 1'b0;
            irq_r <= 1'b0;
        end
        else if (clr)
        begin
            busy_r <= 1'b0;
            done_r <= 1'b0;
            irq_r <= 1'b0;
        end
        else if (go)
        begin
            busy_r <= 1'b1;
            done_r <= 1'b0;
            irq_r <= 1'b0;
        end
        else if (refuse_ev || state_r == ST_FINISH)
        begin
            busy_r <= 1'b0;
            done_r <= 1'b1;
            irq_r <= 1'b1;
        end
        else if (start_ok)
        begin
            done_r <= 1'b0;
            irq_r <= 1'b0;
        end
    end

    // =========================================================
    // register read port
    wire [15:0] status_word = {4'h0, irq_r, sel_ready, sel_protect, sel_loadpt,
        eof_r, parity_r, done_r, busy_r, illegal_r, 1'b0, late_r, error_flag};
    wire [15:0] rd_mux =
        (addr == `REG_CMD) ? {10'h0, cmd_r, unit_r} :
        (addr == `REG_STATUS) ? status_word :
        (addr == `REG_WCOUNT) ? wcount_r :
        (addr == `REG_XPORT) ? {13'h0, unit_r} : 16'h0;

    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
            rdata_r <= 16'h0;
        else if (rd)
            rdata_r <= rd_mux;
        else
            rdata_r <= 16'h0;
    end

    assign rdata = rdata_r;
    assign busy = busy_r;
    assign done = done_r;
    assign irq = irq_r;
    assign motion = running || (state_r == ST_CHECK);
    // nrzi write ends the record once the word after a late answer goes out
    assign write_stop = running && is_write && sel_nrzi && late_r && chan_word;
    assign eof_even_parity = sel_nrzi && sel_7track;

    // =========================================================
    // assertions
    a_illegal_sticky: assert property (@(posedge clk) disable iff (!rstn)
        illegal_r && !clr |=> illegal_r) else $error("illegal dropped");
    a_refuse_flags: assert property (@(posedge clk) disable iff (!rstn)
        refuse_ev |=> illegal_r && done_r && !busy_r) else $error("refuse flags");
    a_clear_zero: assert property (@(posedge clk) disable iff (!rstn)
        clr |=> !error_flag && unit_r == 3'h0 && cmd_r == `CMD_READ) else $error("clear");
    a_error_sum: assert property (@(posedge clk) disable iff (!rstn)
        (illegal_r || late_r || parity_r || eof_r) |-> status_word[`ST_ERROR])
        else $error("error sum");
    a_run_busy: assert property (@(posedge clk) disable iff (!rstn)
        running |-> busy_r && !done_r) else $error("busy while running");
    a_finish_done: assert property (@(posedge clk) disable iff (!rstn)
        state_r == ST_FINISH && !clr |=> done_r && irq_r && !busy_r) else $error("finish");
    a_late_flag: assert property (@(posedge clk) disable iff (!rstn)
        late_ev && is_read && !(clr || wc_ovf || record_end_gap || eof_ev) |=> late_r && running)
        else $error("late");
    a_eof_end: assert property (@(posedge clk) disable iff (!rstn)
        eof_ev && !clr |=> eof_r ##1 (done_r || $past(clr))) else $error("eof end");
    a_stop_hold: assert property (@(posedge clk) disable iff (!rstn)
        stop_pend_r && start && !clr |=> !busy_r) else $error("start before stop");
    c_erase: cover property (@(posedge clk) disable iff (!rstn)
        go && cmd_r == `CMD_ERASE);
    c_refuse: cover property (@(posedge clk) disable iff (!rstn) refuse_ev);
    c_lrc_err: cover property (@(posedge clk) disable iff (!rstn) lrc_ev);
endmodule
`default_nettype wire

// file: sim/tape_xport_model.sv
// transport and host data channel stand-in facing the error logic
`timescale 1ns/100ps
`default_nettype none
module tape_xport_model
(
    input wire logic clk,
    output logic [7:0] unit_ready,
    output logic [7:0] unit_protect,
    output logic [7:0] unit_loadpt,
    output logic [7:0] unit_nrzi,
    output logic [7:0] unit_7track,
    output logic char_valid,
    output logic [8:0] char_in,
    output logic char_parity_bad,
    output logic lrc_valid,
    output logic [8:0] lrc_char,
    output logic record_end_gap,
    output logic file_mark,
    output logic chan_word,
    output logic chan_late,
    output logic spaced_record
);
    // ==========================================================
    // straps: unit 2 offline, 3 protected, 4 at load point, 5-6 nrzi, 6 seven-track
    initial
    begin
        unit_ready = 8'hfb;
        unit_protect = 8'h08;
        unit_loadpt = 8'h10;
        unit_nrzi = 8'h60;
        unit_7track = 8'h40;
        {char_valid, char_parity_bad, lrc_valid} = 3'h0;
        char_in = 9'h000;
        lrc_char = 9'h000;
        {record_end_gap, file_mark, chan_word, chan_late, spaced_record} = 5'h00;
    end
    // ==========================================================
    // one-cycle events; the channel only answers late when the bench asks
    task automatic ev(input logic [4:0] m);
        @(posedge clk);
        {record_end_gap, file_mark, chan_word, chan_late, spaced_record} <= m;
        @(posedge clk);
        {record_end_gap, file_mark, chan_word, chan_late, spaced_record} <= 5'h00;
    endtask
    // released character bus shows junk, not the last value
    task automatic chr(input logic [8:0] c, input logic bad, input logic lrc);
        @(posedge clk);
        char_valid <= !lrc;
        lrc_valid <= lrc;
        char_in <= c;
        lrc_char <= c;
        char_parity_bad <= bad;
        @(posedge clk);
        {char_valid, char_parity_bad, lrc_valid} <= 3'h0;
        char_in <= ~c;
        lrc_char <= ~c;
    endtask
endmodule
`default_nettype wire

// file: sim/tb.sv
// self-checking bench for the tape transfer error logic
`timescale 1ns/100ps
`default_nettype none
`include "tape_err_params.svh"
`define CHK(a, b) \
    begin \
        n_compared++; \
        if ((a) !== (b)) \
        begin \
            n_errors++; \
            $display("Error at %0t: got %h expected %h", $time, (a), (b)); \
        end \
    end
module tb;
    localparam logic [7:0] F_ERR = 8'h01;
    localparam logic [7:0] F_LATE = 8'h02;
    localparam logic [7:0] F_ILL = 8'h08;
    localparam logic [7:0] F_BUSY = 8'h10;
    localparam logic [7:0] F_DONE = 8'h20;
    localparam logic [7:0] F_PAR = 8'h40;
    localparam logic [7:0] F_EOF = 8'h80;
    localparam logic [4:0] EV_GAP = 5'h10;
    localparam logic [4:0] EV_MARK = 5'h08;
    localparam logic [4:0] EV_WORD = 5'h04;
    localparam logic [4:0] EV_LATE = 5'h02;
    localparam logic [4:0] EV_SPACED = 5'h01;
    logic clk, rstn, wr, rd, start, clear_cmd, io_reset, ws_seen;
    logic [3:0] addr;
    logic [15:0] wdata, st;
    logic [8:0] acc, c;
    logic [2:0] op [6] = '{`CMD_SPREV, `CMD_SPFWD, `CMD_WRITE, `CMD_WRITE, `CMD_WEOF, `CMD_READ};
    logic [2:0] un [6] = '{3'h4, 3'h2, 3'h3, 3'h2, 3'h2, 3'h2};
    wire logic [15:0] rdata;
    wire logic [7:0] u_rdy, u_prot, u_lp, u_nrzi, u_7t;
    wire logic cv, cbad, lv, gap, fmark, cword, clate, spaced;
    wire logic [8:0] cin, lchar;
    wire logic write_stop, eof_even_parity, motion, busy, done, irq;
    int n_errors = 0;
    int n_compared = 0;
    int seed = 24755;
    int n, k, m;

    tape_transfer_error_logic #(.ERASE_CYCLES(10), .STOP_CYCLES(5), .NUNITS(8)) dut_u (
        .clk(clk), .rstn(rstn), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
        .start(start), .clear_cmd(clear_cmd), .io_reset(io_reset), .unit_ready(u_rdy),
        .unit_protect(u_prot), .unit_loadpt(u_lp), .unit_nrzi(u_nrzi), .unit_7track(u_7t),
        .char_valid(cv), .char_in(cin), .char_parity_bad(cbad),
        .longitudinal_check_char_valid(lv), .longitudinal_check_char(lchar),
        .record_end_gap(gap), .file_mark(fmark), .chan_word(cword), .chan_late(clate),
        .spaced_record(spaced), .write_stop(write_stop), .eof_even_parity(eof_even_parity),
        .motion(motion), .busy(busy), .done(done), .irq(irq));
    tape_xport_model xp_u (
        .clk(clk), .unit_ready(u_rdy), .unit_protect(u_prot), .unit_loadpt(u_lp),
        .unit_nrzi(u_nrzi), .unit_7track(u_7t), .char_valid(cv), .char_in(cin),
        .char_parity_bad(cbad), .lrc_valid(lv), .lrc_char(lchar), .record_end_gap(gap),
        .file_mark(fmark), .chan_word(cword), .chan_late(clate), .spaced_record(spaced));

    // ==========================================================
    // bus and control tasks; each one that drives a strobe starts on a fresh edge so no strobe is set twice
    task automatic wreg(input logic [3:0] a, input logic [15:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    task automatic rreg(input logic [3:0] a, output logic [15:0] v);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        v = rdata;
    endtask
    task automatic cmd(input logic [2:0] cc, input logic [2:0] u);
        wreg(`REG_CMD, {10'h000, cc, u});
    endtask
    // spaced past the stop time, since early starts are held back silently
    task automatic go();
        repeat (8) @(posedge clk);
        start <= 1'b1;
        @(posedge clk);
        start <= 1'b0;
        #1;
    endtask
    task automatic clr(input logic io);
        @(posedge clk);
        if (io)
            io_reset <= 1'b1;
        else
            clear_cmd <= 1'b1;
        @(posedge clk);
        io_reset <= 1'b0;
        clear_cmd <= 1'b0;
        #1;
    endtask
    task automatic wait_done(input int lim, output int cnt);
        cnt = 0;
        while (done !== 1'b1 && cnt < lim)
        begin
            @(posedge clk);
            #1;
            cnt++;
        end
    endtask
    task automatic expect_fl(input logic [7:0] e);
        rreg(`REG_STATUS, st);
        `CHK(st[7:0] & 8'hfb, e)
    endtask
    task automatic print_verdict();
        if (n_errors == 0 && n_compared > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    // ==========================================================
    // clock, watchdog, write-stop monitor
    initial
    begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    initial
    begin
        repeat (20000) @(posedge clk);
        n_errors++;
        print_verdict();
    end
    always @(posedge clk)
        if (write_stop === 1'b1)
            ws_seen <= 1'b1;

    // ==========================================================
    // scenarios
    initial
    begin
        {rstn, wr, rd, start, clear_cmd, io_reset, ws_seen} = 7'h00;
        addr = 4'h0;
        wdata = 16'h0000;
        repeat (8) @(posedge clk);
        rstn <= 1'b1;
        repeat (6) @(posedge clk);
        rreg(`REG_STATUS, st);
        `CHK(st & 16'h04fb, 16'h0400) // unit 0 idle and ready
        rreg(4'h9, st);
        `CHK(st, 16'h0000)
        // refused starts, alternating clear and io reset
        for (k = 0; k < 6; k++)
        begin
            cmd(op[k], un[k]);
            go();
            wait_done(20, n);
            expect_fl(F_ERR | F_ILL | F_DONE);
            `CHK(st[`ST_READY], u_rdy[un[k]])
            `CHK(irq, 1'b1)
            if (k < 5)
            begin
                clr(k[0]);
                rreg(`REG_CMD, st);
                `CHK(st, 16'h0000)
                expect_fl(8'h00);
            end
        end
        // erase keeps the earlier illegal flag
        cmd(`CMD_ERASE, 3'h0);
        go();
        `CHK({busy, done, motion}, 3'b101)
        wait_done(40, n);
        `CHK(n >= 9 && n <= 14, 1'b1)
        expect_fl(F_ERR | F_ILL | F_DONE);
        clr(1'b1);
        // pe read: late word and bad character do not stop it, file mark does
        wreg(`REG_WCOUNT, 16'h0000);
        cmd(`CMD_READ, 3'h0);
        go();
        repeat (3 + ($random(seed) & 3))
        begin
            xp_u.chr(9'($random(seed)), 1'b0, 1'b0);
            xp_u.ev(EV_WORD);
        end
        xp_u.ev(EV_LATE);
        xp_u.chr(9'($random(seed)), 1'b1, 1'b0);
        expect_fl(F_ERR | F_LATE | F_PAR | F_BUSY);
        xp_u.ev(EV_MARK);
        wait_done(20, n);
        expect_fl(F_ERR | F_LATE | F_PAR | F_EOF | F_DONE);
        clr(1'b0);
        // word counter overflow on words, and on spaced records while spacing
        for (k = 0; k < 2; k++)
        begin
            m = 2 + ($random(seed) & 3);
            wreg(`REG_WCOUNT, 16'(-m));
            cmd(k ? `CMD_SPFWD : `CMD_READ, 3'h0);
            go();
            repeat (m - 1) xp_u.ev(k ? EV_SPACED : EV_WORD);
            `CHK(busy, 1'b1)
            xp_u.ev(k ? EV_SPACED : EV_WORD);
            wait_done(6, n);
            expect_fl(F_DONE);
            @(posedge clk);
            start <= 1'b1; // lands inside the stop time
            @(posedge clk);
            start <= 1'b0;
            #1;
            `CHK(busy, 1'b0)
            clr(1'b0);
        end
        // nrzi check character: bad, then good after an early overflow
        for (k = 0; k < 2; k++)
        begin
            wreg(`REG_WCOUNT, {16{k[0]}});
            cmd(`CMD_READ, 3'h5);
            go();
            if (k)
                xp_u.ev(EV_WORD);
            acc = 9'h000;
            repeat (6)
            begin
                c = 9'($random(seed));
                acc = acc ^ c;
                xp_u.chr(c, 1'b0, 1'b0);
            end
            xp_u.ev(EV_GAP);
            xp_u.chr(acc ^ {8'h00, !k[0]}, 1'b0, 1'b1);
            wait_done(20, n);
            expect_fl(k ? F_DONE : (F_ERR | F_PAR | F_DONE));
            clr(1'b0);
        end
        // late channel while writing: pe keeps going, nrzi cuts the record
        for (k = 0; k < 2; k++)
        begin
            wreg(`REG_WCOUNT, 16'hfff8);
            cmd(`CMD_WRITE, k ? 3'h5 : 3'h0);
            go();
            ws_seen <= 1'b0;
            xp_u.ev(EV_WORD);
            xp_u.ev(EV_LATE);
            xp_u.ev(EV_WORD);
            repeat (3) @(posedge clk);
            `CHK(ws_seen, k[0])
            rreg(`REG_STATUS, st);
            `CHK(st[1:0], 2'h3)
            clr(1'b1);
            `CHK(busy, 1'b0)
        end
        // file mark parity on seven-track versus nine-track nrzi
        for (k = 0; k < 2; k++)
        begin
            cmd(`CMD_WEOF, k ? 3'h6 : 3'h5);
            go();
            repeat (2) @(posedge clk);
            `CHK(eof_even_parity, k[0])
            clr(1'b0);
        end
        print_verdict();
    end
endmodule
`default_nettype wire
